//--- lie_bit_merge.v
`timescale 1ns/1ps
`include "lie_regs.vh"
module lie_bit_merge (
  input  wire [7:0] i_dst,
  input  wire [7:0] i_src,
  input  wire [2:0] i_bit,
  input  wire       i_store,
  output wire [7:0] o_result
);
  wire       sel_bit;
  wire [7:0] mask;
  assign sel_bit  = i_store ? i_src[0] : i_src[i_bit];
  assign mask     = i_store ? (8'h01 << i_bit) : 8'h01;
  assign o_result = (i_dst & ~mask) | (sel_bit ? mask : 8'h00);
endmodule // lie_bit_merge

//--- lie_load_exec.v
`timescale 1ns/1ps
`include "lie_regs.vh"
module lie_load_exec #(
  parameter CYC_W = 4
) (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_start,
  input  wire [7:0]  i_fetch_data,
  output wire        o_busy,
  output reg         o_fetch_req,
  output reg         o_done,
  output reg         o_illegal,
  output reg  [7:0]  o_rf_addr,
  output reg  [7:0]  o_rf_wdata,
  output reg         o_rf_we,
  input  wire [7:0]  i_rf_rdata,
  output reg  [15:0] o_mem_addr,
  output reg  [7:0]  o_mem_wdata,
  output reg         o_code_req,
  output reg         o_data_req,
  output reg         o_mem_we,
  input  wire [7:0]  i_mem_rdata
);
  localparam ST_IDLE  = 8'h01;
  localparam ST_FETCH = 8'h02;
  localparam ST_RDA   = 8'h04;
  localparam ST_RDB   = 8'h08;
  localparam ST_RDC   = 8'h10;
  localparam ST_MEM   = 8'h20;
  localparam ST_WR    = 8'h40;
  localparam ST_PAD   = 8'h80;

  reg [7:0]       state_q;
  reg [7:0]       op_q;
  reg [7:0]       b1_q;
  reg [7:0]       b2_q;
  reg [7:0]       b3_q;
  reg [1:0]       nbytes_q;
  reg [1:0]       got_q;
  reg [7:0]       va_q;
  reg [7:0]       vb_q;
  reg [7:0]       vc_q;
  reg [CYC_W-1:0] cyc_q;
  reg [CYC_W-1:0] total_q;

  wire [7:0] bit_res;

  function [7:0] wreg;
    input [3:0] n;
    begin
      wreg = `LIE_WREG_BASE | {4'h0, n};
    end
  endfunction

  function [1:0] op_len;
    input [7:0] op;
    begin
      case (op)
        `LIE_OP_MOVE_WIW, `LIE_OP_MOVE_IWW, `LIE_OP_MEM_LD, `LIE_OP_MEM_ST: op_len = 2'd1;
        `LIE_OP_MOVE_RR, `LIE_OP_MOVE_RIR, `LIE_OP_MOVE_RIM, `LIE_OP_MOVE_IRIM,
        `LIE_OP_MOVE_IRR, `LIE_OP_MOVE_XLD, `LIE_OP_MOVE_XST, `LIE_OP_BIT,
        `LIE_OP_MEM_XS_LD, `LIE_OP_MEM_XS_ST: op_len = 2'd2;
        `LIE_OP_MEM_XL_LD, `LIE_OP_MEM_XL_ST: op_len = 2'd3;
        default: op_len = 2'd1;
      endcase
    end
  endfunction

  function [CYC_W-1:0] op_cyc;
    input [7:0] op;
    begin
      case (op)
        `LIE_OP_MEM_LD, `LIE_OP_MEM_ST: op_cyc = `LIE_CYC_MEM;
        `LIE_OP_MEM_XS_LD, `LIE_OP_MEM_XS_ST: op_cyc = `LIE_CYC_MEM_XS;
        `LIE_OP_MEM_XL_LD, `LIE_OP_MEM_XL_ST: op_cyc = `LIE_CYC_MEM_XL;
        `LIE_OP_MOVE_WIW, `LIE_OP_MOVE_IWW: op_cyc = `LIE_CYC_SHORT;
        default: op_cyc = (op_len(op) == 2'd1) ? `LIE_CYC_SHORT : `LIE_CYC_THREE;
      endcase
    end
  endfunction

  function is_known;
    input [7:0] op;
    begin
      case (op)
        `LIE_OP_MOVE_RR, `LIE_OP_MOVE_RIR, `LIE_OP_MOVE_RIM, `LIE_OP_MOVE_IRIM,
        `LIE_OP_MOVE_IRR, `LIE_OP_MOVE_WIW, `LIE_OP_MOVE_IWW, `LIE_OP_MOVE_XLD,
        `LIE_OP_MOVE_XST, `LIE_OP_BIT, `LIE_OP_MEM_LD, `LIE_OP_MEM_ST,
        `LIE_OP_MEM_XS_LD, `LIE_OP_MEM_XS_ST, `LIE_OP_MEM_XL_LD, `LIE_OP_MEM_XL_ST:
          is_known = 1'b1;
        default: is_known = (op[3:0] == `LIE_NIB_MOVE_IM) || (op[3:0] == `LIE_NIB_MOVE_RW) ||
                            (op[3:0] == `LIE_NIB_MOVE_WR);
      endcase
    end
  endfunction

  wire [3:0] hi1 = b1_q[7:4];
  wire [3:0] lo1 = b1_q[3:0];
  wire       nib_form = (op_q[3:0] == `LIE_NIB_MOVE_IM) || (op_q[3:0] == `LIE_NIB_MOVE_RW) ||
                        (op_q[3:0] == `LIE_NIB_MOVE_WR);
  wire       mem_op = (op_q == `LIE_OP_MEM_LD) || (op_q == `LIE_OP_MEM_ST) ||
                      (op_q == `LIE_OP_MEM_XS_LD) || (op_q == `LIE_OP_MEM_XS_ST) ||
                      (op_q == `LIE_OP_MEM_XL_LD) || (op_q == `LIE_OP_MEM_XL_ST);
  wire       mem_store = (op_q == `LIE_OP_MEM_ST) || (op_q == `LIE_OP_MEM_XS_ST) ||
                         (op_q == `LIE_OP_MEM_XL_ST);
  wire       is_xl = (op_q == `LIE_OP_MEM_XL_LD) || (op_q == `LIE_OP_MEM_XL_ST);
  wire       direct = is_xl && ((lo1 == `LIE_DA_CODE) || (lo1 == `LIE_DA_DATA));
  // Pair addressed forms pick space from pair parity; absolute form from bit 0 too
  wire       data_space = lo1[0];
  wire [15:0] pair_addr = {va_q, vb_q};
  wire [15:0] offset = (op_q == `LIE_OP_MEM_XS_LD || op_q == `LIE_OP_MEM_XS_ST) ?
                       {8'h00, b2_q} : is_xl ? {b3_q, b2_q} : 16'h0000;
  wire [15:0] eff_addr = direct ? {b3_q, b2_q} : pair_addr + offset;
  wire        bit_store = b1_q[0];
  // Index sum is cut to the 8-bit register space on purpose
  wire [8:0]  idx_sum = {1'b0, b2_q} + {1'b0, va_q};
  reg  [7:0]  rf_waddr_q;

  assign o_busy = (state_q != ST_IDLE);

  lie_bit_merge u_bit_merge (
    .i_dst    (va_q),
    .i_src    (vb_q),
    .i_bit    (b1_q[3:1]),
    .i_store  (bit_store),
    .o_result (bit_res)
  );

  // Register file read address for read phases A, B and C
  reg [7:0] rd_addr;
  always @* begin
    rd_addr = 8'h00;
    case (state_q)
      ST_RDA: begin
        if (nib_form)
          rd_addr = (op_q[3:0] == `LIE_NIB_MOVE_WR) ? wreg(op_q[7:4]) : b1_q;
        else if (mem_op)
          rd_addr = direct ? wreg(hi1) : wreg({lo1[3:1], 1'b0});
        else if (op_q == `LIE_OP_BIT)
          rd_addr = bit_store ? b2_q : wreg(hi1);
        else if (op_q == `LIE_OP_MOVE_XLD || op_q == `LIE_OP_MOVE_XST)
          rd_addr = wreg(lo1);
        else if (op_q == `LIE_OP_MOVE_RR || op_q == `LIE_OP_MOVE_RIR)
          rd_addr = b1_q;
        else if (op_q == `LIE_OP_MOVE_WIW)
          rd_addr = wreg(lo1);
        else if (op_q == `LIE_OP_MOVE_IWW)
          rd_addr = wreg(hi1);
        else
          rd_addr = (op_q == `LIE_OP_MOVE_IRR) ? b1_q : b1_q;
      end
      ST_RDB: begin
        if (mem_op)
          rd_addr = wreg({lo1[3:1], 1'b1});
        else if (op_q == `LIE_OP_BIT)
          rd_addr = bit_store ? wreg(hi1) : b2_q;
        else if (op_q == `LIE_OP_MOVE_XLD)
          rd_addr = idx_sum[7:0];
        else if (op_q == `LIE_OP_MOVE_XST)
          rd_addr = wreg(hi1);
        else if (op_q == `LIE_OP_MOVE_IWW)
          rd_addr = wreg(lo1);
        else if (op_q == `LIE_OP_MOVE_IRR)
          rd_addr = b2_q;
        else
          rd_addr = va_q;
      end
      ST_RDC: rd_addr = (op_q == `LIE_OP_MOVE_IRR) ? b2_q : wreg(hi1);
      default: rd_addr = 8'h00;
    endcase
  end

  // Number of register reads before write or memory phase; pair stores add a third read in ST_RDC
  function [1:0] op_reads;
    input [7:0] op;
    input       nib;
    begin
      if (nib)
        op_reads = (op[3:0] == `LIE_NIB_MOVE_IM) ? 2'd0 : 2'd1;
      else
        case (op)
          `LIE_OP_MOVE_RIM: op_reads = 2'd0;
          `LIE_OP_MOVE_IRIM, `LIE_OP_MOVE_RR: op_reads = 2'd1;
          `LIE_OP_MEM_LD, `LIE_OP_MEM_XS_LD: op_reads = 2'd2;
          `LIE_OP_MEM_XL_LD: op_reads = 2'd2;
          `LIE_OP_MOVE_IRR: op_reads = 2'd2;
          default: op_reads = 2'd2;
        endcase
    end
  endfunction

  // Destination register and value for the write phase
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  always @* begin
    wr_addr = 8'h00;
    wr_data = va_q;
    if (nib_form) begin
      case (op_q[3:0])
        `LIE_NIB_MOVE_IM: begin wr_addr = wreg(op_q[7:4]); wr_data = b1_q; end
        `LIE_NIB_MOVE_RW: begin wr_addr = wreg(op_q[7:4]); wr_data = va_q; end
        default:          begin wr_addr = b1_q;            wr_data = va_q; end
      endcase
    end else
      case (op_q)
        `LIE_OP_MOVE_RR:   begin wr_addr = b2_q; wr_data = va_q; end
        `LIE_OP_MOVE_RIR:  begin wr_addr = b2_q; wr_data = vb_q; end
        `LIE_OP_MOVE_RIM:  begin wr_addr = b1_q; wr_data = b2_q; end
        `LIE_OP_MOVE_IRIM: begin wr_addr = va_q; wr_data = b2_q; end
        `LIE_OP_MOVE_IRR:  begin wr_addr = vb_q; wr_data = va_q; end
        `LIE_OP_MOVE_WIW:  begin wr_addr = wreg(hi1); wr_data = vb_q; end
        `LIE_OP_MOVE_IWW:  begin wr_addr = va_q; wr_data = vb_q; end
        `LIE_OP_MOVE_XLD:  begin wr_addr = wreg(hi1); wr_data = vb_q; end
        `LIE_OP_MOVE_XST:  begin wr_addr = idx_sum[7:0]; wr_data = vb_q; end
        `LIE_OP_BIT:       begin wr_addr = bit_store ? b2_q : wreg(hi1); wr_data = bit_res; end
        default:           begin wr_addr = wreg(hi1); wr_data = vc_q; end
      endcase
  end

  // Read phases present their address at once so each read takes one cycle
  always @* begin
    if (state_q == ST_RDA || state_q == ST_RDB || state_q == ST_RDC)
      o_rf_addr = rd_addr;
    else
      o_rf_addr = rf_waddr_q;
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q     <= ST_IDLE;
      op_q        <= 8'h00;
      b1_q        <= 8'h00;
      b2_q        <= 8'h00;
      b3_q        <= 8'h00;
      nbytes_q    <= 2'd0;
      got_q       <= 2'd0;
      va_q        <= 8'h00;
      vb_q        <= 8'h00;
      vc_q        <= 8'h00;
      cyc_q       <= {CYC_W{1'b0}};
      total_q     <= {CYC_W{1'b0}};
      o_fetch_req <= 1'b0;
      o_done      <= 1'b0;
      o_illegal   <= 1'b0;
      rf_waddr_q  <= 8'h00;
      o_rf_wdata  <= 8'h00;
      o_rf_we     <= 1'b0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_code_req  <= 1'b0;
      o_data_req  <= 1'b0;
      o_mem_we    <= 1'b0;
    end else begin
      o_done     <= 1'b0;
      o_illegal  <= 1'b0;
      o_rf_we    <= 1'b0;
      o_code_req <= 1'b0;
      o_data_req <= 1'b0;
      o_mem_we   <= 1'b0;
      o_fetch_req <= 1'b0;
      if (state_q != ST_IDLE)
        cyc_q <= cyc_q + {{(CYC_W-1){1'b0}}, 1'b1};
      case (state_q)
        ST_IDLE: begin
          cyc_q <= {CYC_W{1'b0}};
          if (i_start) begin
            op_q        <= i_fetch_data;
            nbytes_q    <= op_len(i_fetch_data);
            total_q     <= op_cyc(i_fetch_data);
            got_q       <= 2'd0;
            cyc_q       <= {{(CYC_W-1){1'b0}}, 1'b1};
            if (is_known(i_fetch_data)) begin
              state_q     <= ST_FETCH;
              o_fetch_req <= 1'b1;
            end else
              o_illegal <= 1'b1;
          end
        end
        ST_FETCH: begin
          case (got_q)
            2'd0:    b1_q <= i_fetch_data;
            2'd1:    b2_q <= i_fetch_data;
            default: b3_q <= i_fetch_data;
          endcase
          got_q <= got_q + 2'd1;
          if (got_q + 2'd1 == nbytes_q) begin
            // Absolute location loads read no register; absolute stores still pass through the read phases
            if (is_xl && ((b1_q[3:0] == `LIE_DA_CODE) || (b1_q[3:0] == `LIE_DA_DATA)) &&
                !mem_store && got_q == 2'd2)
              state_q <= ST_MEM;
            else if (op_reads(op_q, nib_form) == 2'd0)
              state_q <= ST_WR;
            else
              state_q <= ST_RDA;
          end else
            o_fetch_req <= 1'b1;
        end
        ST_RDA: begin
          va_q    <= i_rf_rdata;
          state_q <= (op_reads(op_q, nib_form) == 2'd1) ? ST_WR : ST_RDB;
        end
        ST_RDB: begin
          vb_q    <= i_rf_rdata;
          if (mem_store && !direct)
            state_q <= ST_RDC;
          else
            state_q <= mem_op ? ST_MEM : ST_WR;
        end
        ST_RDC: begin
          vc_q    <= i_rf_rdata;
          state_q <= mem_op ? ST_MEM : ST_WR;
        end
        ST_MEM: begin
          // Space follows the pair field, operands are all fetched first
          o_mem_addr  <= eff_addr;
          o_mem_wdata <= direct ? va_q : vc_q;
          o_mem_we    <= mem_store;
          o_code_req  <= !data_space;
          o_data_req  <= data_space;
          state_q     <= ST_WR;
        end
        ST_WR: begin
          if (mem_op && !mem_store) begin
            rf_waddr_q <= wreg(hi1);
            o_rf_wdata <= i_mem_rdata;
            o_rf_we    <= 1'b1;
          end else if (!mem_op) begin
            // Only destination written, flags never touched
            rf_waddr_q <= wr_addr;
            o_rf_wdata <= wr_data;
            o_rf_we    <= 1'b1;
          end
          if (cyc_q + {{(CYC_W-1){1'b0}}, 1'b1} >= total_q) begin
            o_done  <= 1'b1;
            state_q <= ST_IDLE;
          end else
            state_q <= ST_PAD;
        end
        ST_PAD: begin
          if (cyc_q + {{(CYC_W-1){1'b0}}, 1'b1} >= total_q) begin
            o_done  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // lie_load_exec

//--- lie_load_monitor.sv
`timescale 1ns/1ps
module lie_load_monitor (
  input wire       i_core_clk,
  input wire       i_reset,
  input wire       i_start,
  input wire [7:0] i_fetch_data,
  input wire       o_busy,
  input wire       o_fetch_req,
  input wire       o_done,
  input wire       o_illegal,
  input wire       o_code_req,
  input wire       o_data_req,
  input wire       o_mem_we
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  wire [7:0] op  = i_fetch_data;
  wire       take = i_start && !o_busy;
  wire       nib = (op[3:0] inside {4'hC, 4'h8, 4'h9}) || (op inside {8'hC7, 8'hD7});
  wire       six = op inside {8'hE4, 8'hE5, 8'hE6, 8'hD6, 8'hF5, 8'h87, 8'h97, 8'h47};
  wire       ten = op inside {8'hC3, 8'hD3};
  wire       twl = op inside {8'hE7, 8'hF7};
  wire       ftn = op inside {8'hA7, 8'hB7};
  wire       mem = o_code_req || o_data_req;
  a_nibble_len: assert property (take && nib |-> ##4 o_done)
    else $error("nibble move did not end in 4 cycles");
  a_three_len: assert property (take && six |-> ##6 o_done)
    else $error("three byte move did not end in 6 cycles");
  a_mem_len: assert property (take && ten |-> ##10 o_done)
    else $error("pair memory load did not end in 10 cycles");
  a_short_len: assert property (take && twl |-> ##12 o_done)
    else $error("short displacement load did not end in 12 cycles");
  a_long_len: assert property (take && ftn |-> ##14 o_done)
    else $error("long displacement load did not end in 14 cycles");
  a_nibble_no_mem: assert property (take && nib |=> !mem [*4])
    else $error("register move touched memory");
  a_space_onehot: assert property (!(o_code_req && o_data_req))
    else $error("code and data requests together");
  a_fetch_then_mem: assert property (mem |-> !o_fetch_req)
    else $error("memory access while operands still fetched");
  a_write_qualified: assert property (o_mem_we |-> mem)
    else $error("memory write without a space request");
  c_nibble: cover property (take && nib);
  c_code_wr: cover property (o_code_req && o_mem_we);
  c_data_rd: cover property (o_data_req && !o_mem_we);
endmodule // lie_load_monitor

bind lie_load_exec lie_load_monitor lie_load_monitor_inst (.i_core_clk, .i_reset, .i_start,
  .i_fetch_data, .o_busy, .o_fetch_req, .o_done, .o_illegal, .o_code_req, .o_data_req, .o_mem_we);

//--- lie_mem_model.sv
`timescale 1ns/1ps
module lie_mem_model (
  input  wire        i_core_clk,
  input  wire [7:0]  i_rf_addr,
  input  wire [7:0]  i_rf_wdata,
  input  wire        i_rf_we,
  output wire [7:0]  o_rf_rdata,
  input  wire [15:0] i_mem_addr,
  input  wire [7:0]  i_mem_wdata,
  input  wire        i_code_req,
  input  wire        i_data_req,
  input  wire        i_mem_we,
  output wire  [7:0] o_mem_rdata
);
  logic [7:0] junk_q = 8'hA5;
  logic [7:0] rf [0:255];
  logic [7:0] code_mem [0:65535];
  logic [7:0] data_mem [0:65535];
  assign o_rf_rdata = rf[i_rf_addr];
  // Read data stands only during the request cycle, otherwise scrambles
  assign o_mem_rdata = ((i_code_req || i_data_req) && !i_mem_we) ?
                       (i_code_req ? code_mem[i_mem_addr] : data_mem[i_mem_addr]) : junk_q;
  always @(posedge i_core_clk) begin
    if (i_rf_we) begin
      rf[i_rf_addr] <= i_rf_wdata;
    end
    // Two separate spaces, each reached only by its own request
    if (i_code_req && i_mem_we) begin
      code_mem[i_mem_addr] <= i_mem_wdata;
    end
    if (i_data_req && i_mem_we) begin
      data_mem[i_mem_addr] <= i_mem_wdata;
    end
    junk_q <= ~junk_q;
  end
endmodule // lie_mem_model

//--- lie_regs.vh
`ifndef LIE_REGS_VH
`define LIE_REGS_VH
// Opcodes
`define LIE_OP_MOVE_RR      8'hE4
`define LIE_OP_MOVE_RIR     8'hE5
`define LIE_OP_MOVE_RIM     8'hE6
`define LIE_OP_MOVE_IRIM    8'hD6
`define LIE_OP_MOVE_IRR     8'hF5
`define LIE_OP_MOVE_WIW     8'hC7
`define LIE_OP_MOVE_IWW     8'hD7
`define LIE_OP_MOVE_XLD     8'h87
`define LIE_OP_MOVE_XST     8'h97
`define LIE_OP_BIT          8'h47
`define LIE_OP_MEM_LD       8'hC3
`define LIE_OP_MEM_ST       8'hD3
`define LIE_OP_MEM_XS_LD    8'hE7
`define LIE_OP_MEM_XS_ST    8'hF7
`define LIE_OP_MEM_XL_LD    8'hA7
`define LIE_OP_MEM_XL_ST    8'hB7
// Low nibble forms
`define LIE_NIB_MOVE_IM     4'hC
`define LIE_NIB_MOVE_RW     4'h8
`define LIE_NIB_MOVE_WR     4'h9
// Direct address pair codes
`define LIE_DA_CODE         4'h0
`define LIE_DA_DATA         4'h1
// Working register bank base in register file
`define LIE_WREG_BASE       8'hC0
// Cycle counts per instruction
`define LIE_CYC_SHORT       4
`define LIE_CYC_THREE       6
`define LIE_CYC_MEM         10
`define LIE_CYC_MEM_XS      12
`define LIE_CYC_MEM_XL      14
`endif

//--- test_load_instruction_execution.sv
`timescale 1ns/1ps
module test_load_instruction_execution;
  logic        i_core_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_start = 1'b0;
  logic [7:0]  i_fetch_data = 8'h00;
  wire         o_busy, o_fetch_req, o_done, o_illegal, o_rf_we;
  wire         o_code_req, o_data_req, o_mem_we;
  wire  [7:0]  o_rf_addr, o_rf_wdata, i_rf_rdata, o_mem_wdata, i_mem_rdata;
  wire  [15:0] o_mem_addr;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #5 i_core_clk = ~i_core_clk;
  lie_load_exec lie_load_exec_inst (.i_core_clk, .i_reset, .i_start, .i_fetch_data, .o_busy,
    .o_fetch_req, .o_done, .o_illegal, .o_rf_addr, .o_rf_wdata, .o_rf_we, .i_rf_rdata,
    .o_mem_addr, .o_mem_wdata, .o_code_req, .o_data_req, .o_mem_we, .i_mem_rdata);
  lie_mem_model lie_mem_model_inst (.i_core_clk(i_core_clk), .i_rf_addr(o_rf_addr),
    .i_rf_wdata(o_rf_wdata), .i_rf_we(o_rf_we), .o_rf_rdata(i_rf_rdata),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .i_code_req(o_code_req),
    .i_data_req(o_data_req), .i_mem_we(o_mem_we), .o_mem_rdata(i_mem_rdata));
  task summarize;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task setr(input logic [7:0] a, input logic [7:0] v);
    lie_mem_model_inst.rf[a] = v;
  endtask
  function logic [7:0] gr(input logic [7:0] a);
    return lie_mem_model_inst.rf[a];
  endfunction
  // Bytes in b go out opcode first; each operand follows a fetch request
  task automatic run(input logic [31:0] b, input int ncyc, input bit hold);
    int   cnt;
    int   idx;
    cnt = 0;
    idx = 1;
    i_start = 1'b1;
    i_fetch_data = b[31:24];
    do begin
      @(posedge i_core_clk);
      #1;
      cnt++;
      if (!hold) i_start = 1'b0;
      if (o_fetch_req === 1'b1 && idx < 4) begin
        i_fetch_data = b[31 - 8 * idx -: 8];
        idx++;
      end
    end while (o_done !== 1'b1 && cnt < 40);
    i_start = 1'b0;
    if (o_done !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      summarize();
    end
    chk(cnt, ncyc);
    // The final register write can land on the edge after the one that raises the done pulse
    @(posedge i_core_clk);
    #1;
  endtask
  task t_nibble;
    setr(8'hC3, 8'h00);
    setr(8'h10, 8'h77);
    setr(8'hC1, 8'h3E);
    run(32'h3C5A0000, 4, 0);
    chk(gr(8'hC3), 8'h5A);
    run(32'h28100000, 4, 0);
    chk(gr(8'hC2), 8'h77);
    chk(gr(8'h10), 8'h77);
    run(32'h19200000, 4, 0);
    chk(gr(8'h20), 8'h3E);
    $display("t_nibble finished");
  endtask
  task t_index;
    setr(8'hC1, 8'h0A);
    setr(8'h3A, 8'hFF);
    run(32'h87013000, 6, 0);
    chk(gr(8'hC0), 8'hFF);
    setr(8'hC0, 8'h01);
    run(32'h97103000, 6, 1);
    chk(gr(8'h31), 8'h0A);
    chk(gr(8'hC1), 8'h0A);
    $display("t_index finished");
  endtask
  task t_bit;
    setr(8'hC0, 8'h06);
    setr(8'h00, 8'h05);
    run(32'h47040000, 6, 0);
    chk(gr(8'hC0), 8'h07);
    chk(gr(8'h00), 8'h05);
    setr(8'hC0, 8'h06);
    run(32'h47010000, 6, 0);
    chk(gr(8'h00), 8'h04);
    chk(gr(8'hC0), 8'h06);
    setr(8'hC0, 8'h01);
    setr(8'h00, 8'h00);
    run(32'h470F0000, 6, 0);
    chk(gr(8'h00), 8'h80);
    $display("t_bit finished");
  endtask
  task t_mem;
    setr(8'hC2, 8'h01);
    setr(8'hC3, 8'h04);
    lie_mem_model_inst.code_mem[16'h0104] = 8'h1A;
    lie_mem_model_inst.data_mem[16'h0104] = 8'h2A;
    lie_mem_model_inst.data_mem[16'h0105] = 8'h7D;
    lie_mem_model_inst.code_mem[16'h1104] = 8'h88;
    lie_mem_model_inst.data_mem[16'h1104] = 8'h98;
    lie_mem_model_inst.code_mem[16'h1105] = 8'h00;
    run(32'hC3020000, 10, 0);
    chk(gr(8'hC0), 8'h1A);
    run(32'hC3030000, 10, 0);
    chk(gr(8'hC0), 8'h2A);
    run(32'hE7030100, 12, 0);
    chk(gr(8'hC0), 8'h7D);
    run(32'hA7020010, 14, 1);
    chk(gr(8'hC0), 8'h88);
    run(32'hA7010411, 14, 0);
    chk(gr(8'hC0), 8'h98);
    run(32'hA7000411, 14, 0);
    chk(gr(8'hC0), 8'h88);
    setr(8'hC0, 8'h11);
    run(32'hD3020000, 10, 0);
    chk(lie_mem_model_inst.code_mem[16'h0104], 8'h11);
    chk(lie_mem_model_inst.data_mem[16'h0104], 8'h2A);
    run(32'hF7030100, 12, 0);
    chk(lie_mem_model_inst.data_mem[16'h0105], 8'h11);
    run(32'hB7010511, 14, 0);
    chk(lie_mem_model_inst.data_mem[16'h1105], 8'h11);
    chk(lie_mem_model_inst.code_mem[16'h1105], 8'h00);
    run(32'hB7030020, 14, 0);
    chk(lie_mem_model_inst.data_mem[16'h2104], 8'h11);
    chk({gr(8'hC2), gr(8'hC3)}, 16'h0104);
    $display("t_mem finished");
  endtask
  task t_illegal;
    int   k;
    logic seen;
    seen = 1'b0;
    i_start = 1'b1;
    i_fetch_data = 8'h00;
    for (k = 0; k < 3; k++) begin
      @(posedge i_core_clk);
      #1;
      i_start = 1'b0;
      if (o_illegal === 1'b1) seen = 1'b1;
      chk(o_done, 1'b0);
    end
    chk(seen, 1'b1);
    run(32'h3C990000, 4, 0);
    chk(gr(8'hC3), 8'h99);
    $display("t_illegal finished");
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    #1;
    i_reset = 1'b0;
    t_nibble;
    t_index;
    t_bit;
    t_mem;
    t_illegal;
    summarize;
  end
endmodule // test_load_instruction_execution
